// ==== verilog/afidsh_command_handler.sv ====
// AFI/DSFID write and lock command handler with system information reply.
// Assumes same-clock inputs: a decoded request with CRC already checked,
// an end-of-frame-only request strobe, and a nonvolatile write engine that
// answers each held write request with a one-cycle done pulse.

// Function
// - WriteAFI stores the byte when unlocked and unprotected or session open.
// - Successful write or lock replies flags 00h then CRC, no payload.
// - Bad format gives error 02h; bad request flags give error 03h.
// - WriteAFI refused gives 12h; failed AFI programming gives 13h.
// - LockAFI sets the lock when unlocked and unprotected or session open.
// - LockAFI errors: 11h already locked, 12h protected, 14h program fail.
// - Option flag set holds the reply after a write or lock cycle until the next EOF.
// - WriteDSFID stores the byte only while the DSFID lock is clear.
// - WriteDSFID errors: 12h locked, 13h programming failed.
// - LockDSFID sets the DSFID lock only when it is still clear.
// - LockDSFID errors: 11h already locked, 14h programming failed.
// - Accepted write and lock replies follow the nonvolatile write cycle.
// - GetSystemInfo uses opcode 2Bh, flags 00xx00xxb; device returns its info.
// - Info reply: flags 00h, info 0Fh, UID, DSFID, AFI, size, IC reference.
module afidsh_command_handler
    import afidsh_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Decoded request and EOF-only request
    input  wire afidsh_req_t req,
    input  wire logic        eofReq,
    // Security state and configuration
    input  wire logic        afiProtectBit,
    input  wire logic        firstUserAreaOpen,
    // Nonvolatile image at power-up
    input  wire logic        nvLoad,
    input  wire afidsh_nv_t  nvImage,
    // Nonvolatile write engine
    output afidsh_nvw_t      nvWrite,
    input  wire logic        nvDone,
    input  wire logic        nvFail,
    // Response to the frame layer
    output afidsh_rsp_t      rsp,
    output logic             busy,
    // Stored identifiers
    output logic [7:0]       afiValue,
    output logic [7:0]       dsfidValue,
    output logic             afiLockBit,
    output logic             dsfidLockBit
);

    afidsh_st_t s_q;
    afidsh_st_t s_d;

    logic       isWriteCmd;
    logic       isOurs;
    logic       addrMode;
    logic       badFlags;
    logic [3:0] wantCount;
    logic       badFormat;
    logic       afiDenied;

    // Request classification
    always_comb
    begin
        isWriteCmd = (req.opcode == OP_WRITE_AFI) || (req.opcode == OP_LOCK_AFI)
                  || (req.opcode == OP_WRITE_DSFID) || (req.opcode == OP_LOCK_DSFID);
        isOurs     = isWriteCmd || (req.opcode == OP_GET_SYSINFO);
        addrMode   = req.flags[FLG_ADDRESS];
        // Flag pattern 0xxx00xxb, select with address is contradictory
        badFlags   = req.flags[FLG_RFU] || req.flags[FLG_PROTO_EXT]
                  || req.flags[FLG_INVENTORY]
                  || (req.flags[FLG_SELECT] && req.flags[FLG_ADDRESS]);
        // System info takes no option
        if ((req.opcode == OP_GET_SYSINFO) && req.flags[FLG_OPTION])
        begin
            badFlags = 1'b1;
        end
        // UID bytes only in addressed mode, one value byte for writes
        wantCount  = addrMode ? UID_BYTES : 4'h0;
        if ((req.opcode == OP_WRITE_AFI) || (req.opcode == OP_WRITE_DSFID))
        begin
            wantCount = wantCount + VALUE_BYTES;
        end
        badFormat  = (req.paramCount != wantCount);
        afiDenied  = afiProtectBit && !firstUserAreaOpen;
    end

    // Next-state logic
    always_comb
    begin
        s_d           = s_q;
        s_d.rsp.valid = 1'b0;
        case (s_q.state)
            ST_IDLE:
            begin
                if (req.valid && isOurs)
                begin
                    s_d.rsp.sysInfo   = 1'b0;
                    s_d.rsp.flags     = RSP_FLAGS_ERR;
                    s_d.rsp.hasCode   = 1'b1;
                    s_d.rsp.infoFlags = 8'h00;
                    s_d.postpone      = req.flags[FLG_OPTION];
                    s_d.nvw.data      = req.value;
                    if (badFlags)
                    begin
                        s_d.rsp.valid = 1'b1;
                        s_d.rsp.code  = ERR_FLAGS;
                    end
                    else if (badFormat)
                    begin
                        s_d.rsp.valid = 1'b1;
                        s_d.rsp.code  = ERR_FORMAT;
                    end
                    else
                    begin
                        case (req.opcode)
                            OP_WRITE_AFI:
                            begin
                                if (s_q.nv.afiLockBit || afiDenied)
                                begin
                                    s_d.rsp.valid = 1'b1;
                                    s_d.rsp.code  = ERR_PROTECT;
                                end
                                else
                                begin
                                    s_d.nvw.req    = 1'b1;
                                    s_d.nvw.target = NV_AFI;
                                    s_d.failCode   = ERR_PROG;
                                    s_d.state      = ST_PROG;
                                end
                            end
                            OP_LOCK_AFI:
                            begin
                                if (s_q.nv.afiLockBit)
                                begin
                                    s_d.rsp.valid = 1'b1;
                                    s_d.rsp.code  = ERR_LOCKED;
                                end
                                else if (afiDenied)
                                begin
                                    s_d.rsp.valid = 1'b1;
                                    s_d.rsp.code  = ERR_PROTECT;
                                end
                                else
                                begin
                                    s_d.nvw.req    = 1'b1;
                                    s_d.nvw.target = NV_AFI_LOCK;
                                    s_d.failCode   = ERR_LOCK_FAIL;
                                    s_d.state      = ST_PROG;
                                end
                            end
                            OP_WRITE_DSFID:
                            begin
                                if (s_q.nv.dsfidLockBit)
                                begin
                                    s_d.rsp.valid = 1'b1;
                                    s_d.rsp.code  = ERR_PROTECT;
                                end
                                else
                                begin
                                    s_d.nvw.req    = 1'b1;
                                    s_d.nvw.target = NV_DSFID;
                                    s_d.failCode   = ERR_PROG;
                                    s_d.state      = ST_PROG;
                                end
                            end
                            OP_LOCK_DSFID:
                            begin
                                if (s_q.nv.dsfidLockBit)
                                begin
                                    s_d.rsp.valid = 1'b1;
                                    s_d.rsp.code  = ERR_LOCKED;
                                end
                                else
                                begin
                                    s_d.nvw.req    = 1'b1;
                                    s_d.nvw.target = NV_DSFID_LOCK;
                                    s_d.failCode   = ERR_LOCK_FAIL;
                                    s_d.state      = ST_PROG;
                                end
                            end
                            default:
                            begin
                                // System information, answered at once
                                s_d.rsp.valid     = 1'b1;
                                s_d.rsp.sysInfo   = 1'b1;
                                s_d.rsp.flags     = RSP_FLAGS_OK;
                                s_d.rsp.hasCode   = 1'b0;
                                s_d.rsp.code      = ERR_NONE;
                                s_d.rsp.infoFlags = INFO_FLAGS;
                            end
                        endcase
                    end
                end
            end
            ST_PROG:
            begin
                // Write engine busy; reply only after its done pulse
                if (nvDone)
                begin
                    s_d.nvw.req = 1'b0;
                    if (nvFail)
                    begin
                        s_d.rsp.code = s_q.failCode;
                    end
                    else
                    begin
                        s_d.rsp.flags   = RSP_FLAGS_OK;
                        s_d.rsp.hasCode = 1'b0;
                        s_d.rsp.code    = ERR_NONE;
                        case (s_q.nvw.target)
                            NV_AFI:        s_d.nv.afi          = s_q.nvw.data;
                            NV_DSFID:      s_d.nv.dsfid        = s_q.nvw.data;
                            NV_AFI_LOCK:   s_d.nv.afiLockBit   = 1'b1;
                            default:       s_d.nv.dsfidLockBit = 1'b1;
                        endcase
                    end
                    if (s_q.postpone)
                    begin
                        s_d.state = ST_HOLD;
                    end
                    else
                    begin
                        s_d.rsp.valid = 1'b1;
                        s_d.state     = ST_IDLE;
                    end
                end
            end
            ST_HOLD:
            begin
                // Postponed reply waits for the EOF-only request
                if (eofReq)
                begin
                    s_d.rsp.valid = 1'b1;
                    s_d.state     = ST_IDLE;
                end
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase
        // Power-up image; lock bits can only be added, never removed
        if (nvLoad && (s_q.state == ST_IDLE))
        begin
            s_d.nv.afi          = nvImage.afi;
            s_d.nv.dsfid        = nvImage.dsfid;
            s_d.nv.afiLockBit   = s_q.nv.afiLockBit | nvImage.afiLockBit;
            s_d.nv.dsfidLockBit = s_q.nv.dsfidLockBit | nvImage.dsfidLockBit;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '{state: ST_IDLE,
                     nv: '{afi: AFI_RESET, dsfid: DSFID_RESET,
                           afiLockBit: 1'b0, dsfidLockBit: 1'b0},
                     nvw: '{req: 1'b0, target: NV_AFI, data: 8'h00},
                     rsp: '{valid: 1'b0, sysInfo: 1'b0, flags: RSP_FLAGS_OK,
                            hasCode: 1'b0, code: ERR_NONE, infoFlags: 8'h00},
                     failCode: ERR_NONE,
                     postpone: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs from the state register
    assign nvWrite      = s_q.nvw;
    assign rsp          = s_q.rsp;
    assign busy         = (s_q.state != ST_IDLE);
    assign afiValue     = s_q.nv.afi;
    assign dsfidValue   = s_q.nv.dsfid;
    assign afiLockBit   = s_q.nv.afiLockBit;
    assign dsfidLockBit = s_q.nv.dsfidLockBit;

endmodule // afidsh_command_handler

// ==== shared/afidsh_pkg.sv ====
// Constants, codes and carriers for the AFI/DSFID command handler.
// Assumes a frame decoder upstream and a nonvolatile write engine beside it.
package afidsh_pkg;

    // Command opcodes
    localparam logic [7:0] OP_WRITE_AFI   = 8'h27;
    localparam logic [7:0] OP_LOCK_AFI    = 8'h28;
    localparam logic [7:0] OP_WRITE_DSFID = 8'h29;
    localparam logic [7:0] OP_LOCK_DSFID  = 8'h2A;
    localparam logic [7:0] OP_GET_SYSINFO = 8'h2B;

    // Request flag positions
    localparam int FLG_PROTO_EXT = 3;
    localparam int FLG_INVENTORY = 2;
    localparam int FLG_SELECT    = 4;
    localparam int FLG_ADDRESS   = 5;
    localparam int FLG_OPTION    = 6;
    localparam int FLG_RFU       = 7;

    // Parameter byte counts
    localparam logic [3:0] UID_BYTES   = 4'h8;
    localparam logic [3:0] VALUE_BYTES = 4'h1;

    // Response flag and error codes
    localparam logic [7:0] RSP_FLAGS_OK  = 8'h00;
    localparam logic [7:0] RSP_FLAGS_ERR = 8'h01;
    localparam logic [7:0] INFO_FLAGS    = 8'h0F;
    localparam logic [7:0] ERR_NONE      = 8'h00;
    localparam logic [7:0] ERR_FORMAT    = 8'h02;
    localparam logic [7:0] ERR_FLAGS     = 8'h03;
    localparam logic [7:0] ERR_LOCKED    = 8'h11;
    localparam logic [7:0] ERR_PROTECT   = 8'h12;
    localparam logic [7:0] ERR_PROG      = 8'h13;
    localparam logic [7:0] ERR_LOCK_FAIL = 8'h14;

    // Values after reset
    localparam logic [7:0] AFI_RESET   = 8'h00;
    localparam logic [7:0] DSFID_RESET = 8'h00;

    // Handler states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PROG = 2'b01,
        ST_HOLD = 2'b10
    } afidsh_state_t;

    // Nonvolatile write target
    typedef enum logic [1:0] {
        NV_AFI        = 2'b00,
        NV_DSFID      = 2'b01,
        NV_AFI_LOCK   = 2'b10,
        NV_DSFID_LOCK = 2'b11
    } afidsh_nvtgt_t;

    // Decoded request from the frame layer
    typedef struct packed {
        logic       valid;
        logic [7:0] flags;
        logic [7:0] opcode;
        logic [3:0] paramCount;
        logic [7:0] value;
    } afidsh_req_t;

    // Nonvolatile image loaded at power-up
    typedef struct packed {
        logic [7:0] afi;
        logic [7:0] dsfid;
        logic       afiLockBit;
        logic       dsfidLockBit;
    } afidsh_nv_t;

    // Nonvolatile write request
    typedef struct packed {
        logic          req;
        afidsh_nvtgt_t target;
        logic [7:0]    data;
    } afidsh_nvw_t;

    // Response to the frame layer
    typedef struct packed {
        logic       valid;
        logic       sysInfo;
        logic [7:0] flags;
        logic       hasCode;
        logic [7:0] code;
        logic [7:0] infoFlags;
    } afidsh_rsp_t;

    // Whole module state
    typedef struct packed {
        afidsh_state_t state;
        afidsh_nv_t    nv;
        afidsh_nvw_t   nvw;
        afidsh_rsp_t   rsp;
        logic [7:0]    failCode;
        logic          postpone;
    } afidsh_st_t;

endpackage

// ==== verif/afidsh_properties.sv ====
// Concurrent checks on the AFI/DSFID command handler ports.
// Assumes afidsh_pkg is compiled first; bound into every handler instance.
module afidsh_checker
    import afidsh_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Request side
    input wire afidsh_req_t req,
    input wire logic        eofReq,
    input wire logic        nvLoad,
    // Write engine side
    input wire afidsh_nvw_t nvWrite,
    input wire logic        nvDone,
    input wire logic        nvFail,
    // Reply and stored values
    input wire afidsh_rsp_t rsp,
    input wire logic        busy,
    input wire logic [7:0]  afiValue,
    input wire logic [7:0]  dsfidValue,
    input wire logic        afiLockBit,
    input wire logic        dsfidLockBit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Request accepted by an idle handler
    logic take;
    assign take = req.valid && !busy && req.opcode inside {[8'h27:8'h2B]};

    a_flag_error: assert property (
        take && req.flags[7] |=> rsp.valid && rsp.flags == RSP_FLAGS_ERR && rsp.code == ERR_FLAGS)
        else $error("reserved flag bit did not give error 03h");
    a_sysinfo_reply: assert property (
        take && req.opcode == OP_GET_SYSINFO && req.flags == 8'h00 && req.paramCount == 4'h0
        |=> rsp.valid && rsp.sysInfo && rsp.flags == RSP_FLAGS_OK && rsp.infoFlags == INFO_FLAGS)
        else $error("system information reply malformed");
    a_afi_lock_stays: assert property (afiLockBit |=> afiLockBit)
        else $error("AFI lock bit cleared");
    a_dsfid_lock_stays: assert property (dsfidLockBit |=> dsfidLockBit)
        else $error("DSFID lock bit cleared");
    a_afi_frozen: assert property (afiLockBit && !nvLoad |=> $stable(afiValue))
        else $error("locked AFI changed");
    a_dsfid_frozen: assert property (dsfidLockBit && !nvLoad |=> $stable(dsfidValue))
        else $error("locked DSFID changed");
    a_nv_held: assert property (
        nvWrite.req && !nvDone |=> nvWrite.req && $stable(nvWrite.data) && $stable(nvWrite.target))
        else $error("write request dropped before done");
    a_afi_stored: assert property (
        nvWrite.req && nvDone && !nvFail && nvWrite.target == NV_AFI
        |=> afiValue == $past(nvWrite.data))
        else $error("AFI not updated after write cycle");
    a_fail_keeps: assert property (
        nvWrite.req && nvDone && nvFail |=> $stable(afiValue) && $stable(dsfidValue)
        && $stable(afiLockBit) && $stable(dsfidLockBit))
        else $error("failed write changed a stored value");
    a_no_early_rsp: assert property (nvWrite.req |-> !rsp.valid)
        else $error("reply during write cycle");
    a_eof_release: assert property (busy && !nvWrite.req && eofReq |=> rsp.valid && !busy)
        else $error("postponed reply not released by EOF");

    // Main scenarios reached
    c_sysinfo: cover property (rsp.valid && rsp.sysInfo);
    c_postponed: cover property (busy && !nvWrite.req && eofReq);
    c_nv_fail: cover property (nvDone && nvFail);
endmodule // afidsh_checker

bind afidsh_command_handler afidsh_checker u_afidsh_checker (
    .core_clk(core_clk), .rst_b(rst_b), .req(req), .eofReq(eofReq), .nvLoad(nvLoad),
    .nvWrite(nvWrite), .nvDone(nvDone), .nvFail(nvFail), .rsp(rsp), .busy(busy),
    .afiValue(afiValue), .dsfidValue(dsfidValue), .afiLockBit(afiLockBit),
    .dsfidLockBit(dsfidLockBit));

// ==== verif/afidsh_nv_model.sv ====
// Behavioural nonvolatile write engine facing the handler.
// Assumes the bench sets latency and failNext between requests.
module afidsh_nv_model
    import afidsh_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // Write request and bench control
    input wire afidsh_nvw_t nvWrite,
    input wire logic [7:0]  latency,
    input wire logic        failNext,
    // Completion
    output logic            nvDone,
    output logic            nvFail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] count_q;

    // Write cycle timer; fail line toggles when not meaningful
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_q <= 8'h00;
            nvDone  <= 1'b0;
            nvFail  <= 1'b0;
        end
        else if (nvWrite.req && !nvDone)
        begin
            count_q <= count_q + 8'h01;
            nvDone  <= (count_q == latency);
            nvFail  <= (count_q == latency) ? failNext : ~nvFail;
        end
        else
        begin
            count_q <= 8'h00;
            nvDone  <= 1'b0;
            nvFail  <= ~nvFail;
        end
    end
endmodule // afidsh_nv_model

// ==== verif/tb.sv ====
// Self-checking bench for the AFI/DSFID command handler.
// Assumes the package, handler, checker and write engine model are compiled.
module tb import afidsh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_b, eofReq, afiProtectBit, firstUserAreaOpen, nvLoad;
    logic        nvDone, nvFail, busy, afiLockBit, dsfidLockBit, failNext;
    logic [7:0]  afiValue, dsfidValue, latency;
    afidsh_req_t req;
    afidsh_nv_t  nvImage;
    afidsh_nvw_t nvWrite;
    afidsh_rsp_t rsp;
    int          n_errors, total_checks;

    afidsh_command_handler u_afidsh_command_handler (.core_clk(core_clk), .rst_b(rst_b),
        .req(req), .eofReq(eofReq), .afiProtectBit(afiProtectBit),
        .firstUserAreaOpen(firstUserAreaOpen), .nvLoad(nvLoad), .nvImage(nvImage),
        .nvWrite(nvWrite), .nvDone(nvDone), .nvFail(nvFail), .rsp(rsp), .busy(busy),
        .afiValue(afiValue), .dsfidValue(dsfidValue), .afiLockBit(afiLockBit),
        .dsfidLockBit(dsfidLockBit));
    afidsh_nv_model u_afidsh_nv_model (.core_clk(core_clk), .rst_b(rst_b),
        .nvWrite(nvWrite), .latency(latency), .failNext(failNext), .nvDone(nvDone),
        .nvFail(nvFail));

    // 250 MHz clock
    always #2 core_clk = ~core_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request; releases a postponed reply with EOF, then judges it
    task automatic xfer(input logic [7:0] flags, input logic [7:0] op, input logic [3:0] cnt,
                        input logic [7:0] val, input logic [7:0] code, input logic expHold);
        logic held;
        held = 1'b0;
        @(negedge core_clk);
        req = '{valid: 1'b1, flags: flags, opcode: op, paramCount: cnt, value: val};
        @(negedge core_clk);
        req.valid = 1'b0;
        for (int i = 0; i < 200 && rsp.valid !== 1'b1; i++)
        begin
            eofReq = (busy === 1'b1 && nvWrite.req === 1'b0 && eofReq === 1'b0);
            held   = held | eofReq;
            @(negedge core_clk);
        end
        eofReq = 1'b0;
        check(8'(rsp.valid), 8'h01);
        check(rsp.flags, (code == ERR_NONE) ? RSP_FLAGS_OK : RSP_FLAGS_ERR);
        check(8'(rsp.hasCode), 8'(code != ERR_NONE));
        check(rsp.code, code);
        check(8'(held), 8'(expHold));
    endtask

    task automatic t_flags;
        for (int k = 0; k < 5; k++)
            xfer(8'h80, 8'h27 + 8'(k), 4'h1, 8'h00, ERR_FLAGS, 1'b0);
        xfer(8'h08, OP_WRITE_AFI, 4'h1, 8'h00, ERR_FLAGS, 1'b0);
        xfer(8'h04, OP_LOCK_AFI, 4'h0, 8'h00, ERR_FLAGS, 1'b0);
        xfer(8'h30, OP_WRITE_DSFID, 4'h9, 8'h00, ERR_FLAGS, 1'b0);
        xfer(8'h40, OP_GET_SYSINFO, 4'h0, 8'h00, ERR_FLAGS, 1'b0);
        $display("test flags done");
    endtask

    task automatic t_format;
        xfer(8'h00, OP_WRITE_AFI, 4'h0, 8'h00, ERR_FORMAT, 1'b0);
        xfer(8'h00, OP_LOCK_AFI, 4'h1, 8'h00, ERR_FORMAT, 1'b0);
        xfer(8'h20, OP_WRITE_DSFID, 4'h1, 8'h00, ERR_FORMAT, 1'b0);
        xfer(8'h00, OP_GET_SYSINFO, 4'h1, 8'h00, ERR_FORMAT, 1'b0);
        $display("test format done");
    endtask

    task automatic t_write;
        xfer(8'h20, OP_WRITE_AFI, 4'h9, 8'hA5, ERR_NONE, 1'b0);
        check(afiValue, 8'hA5);
        latency = 8'h14;
        xfer(8'h40, OP_WRITE_DSFID, 4'h1, 8'h3C, ERR_NONE, 1'b1);
        check(dsfidValue, 8'h3C);
        xfer(8'h00, OP_GET_SYSINFO, 4'h0, 8'h00, ERR_NONE, 1'b0);
        check(rsp.infoFlags, INFO_FLAGS);
        $display("test write done");
    endtask

    task automatic t_protect;
        afiProtectBit = 1'b1;
        xfer(8'h00, OP_WRITE_AFI, 4'h1, 8'h11, ERR_PROTECT, 1'b0);
        xfer(8'h00, OP_LOCK_AFI, 4'h0, 8'h00, ERR_PROTECT, 1'b0);
        check(afiValue, 8'hA5);
        firstUserAreaOpen = 1'b1;
        xfer(8'h00, OP_WRITE_AFI, 4'h1, 8'h5A, ERR_NONE, 1'b0);
        check(afiValue, 8'h5A);
        $display("test protect done");
    endtask

    task automatic t_fail;
        failNext = 1'b1;
        for (int k = 0; k < 4; k++)
            xfer((k == 0) ? 8'h40 : 8'h00, 8'h27 + 8'(k), k[0] ? 4'h0 : 4'h1, 8'hEE,
                 k[0] ? ERR_LOCK_FAIL : ERR_PROG, k == 0);
        check(afiValue, 8'h5A);
        check(dsfidValue, 8'h3C);
        check({6'h00, afiLockBit, dsfidLockBit}, 8'h00);
        failNext = 1'b0;
        $display("test fail done");
    endtask

    task automatic t_lock;
        latency = 8'h00;
        xfer(8'h00, OP_LOCK_AFI, 4'h0, 8'h00, ERR_NONE, 1'b0);
        check(8'(afiLockBit), 8'h01);
        firstUserAreaOpen = 1'b0;
        xfer(8'h00, OP_LOCK_AFI, 4'h0, 8'h00, ERR_LOCKED, 1'b0);
        xfer(8'h00, OP_WRITE_AFI, 4'h1, 8'h99, ERR_PROTECT, 1'b0);
        xfer(8'h40, OP_LOCK_DSFID, 4'h0, 8'h00, ERR_NONE, 1'b1);
        xfer(8'h00, OP_LOCK_DSFID, 4'h0, 8'h00, ERR_LOCKED, 1'b0);
        xfer(8'h00, OP_WRITE_DSFID, 4'h1, 8'h99, ERR_PROTECT, 1'b0);
        nvImage = '{afi: 8'h77, dsfid: 8'h66, afiLockBit: 1'b0, dsfidLockBit: 1'b0};
        nvLoad = 1'b1;
        @(negedge core_clk);
        nvLoad = 1'b0;
        check({6'h00, afiLockBit, dsfidLockBit}, 8'h03);
        check(afiValue, 8'h77);
        check(dsfidValue, 8'h66);
        $display("test lock done");
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        {core_clk, rst_b, eofReq, afiProtectBit, firstUserAreaOpen, nvLoad, failNext} = '0;
        req = '0;
        nvImage = '0;
        latency = 8'h00;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        t_flags();
        t_format();
        t_write();
        t_protect();
        t_fail();
        t_lock();
        print_verdict();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end
endmodule // tb
